// ### shared/dsc_regs.vh
// Register map, field positions, reset values and timing figures of the
// disconnector control block; assumes a byte-addressed 32-bit APB slave.
`ifndef DSC_REGS_VH
`define DSC_REGS_VH

// Byte offsets
`define DSC_ADDR_CTRL    8'h00
`define DSC_ADDR_CMD     8'h04
`define DSC_ADDR_MAXOP   8'h08
`define DSC_ADDR_PULSE   8'h0C
`define DSC_ADDR_INTER   8'h10
`define DSC_ADDR_SBO     8'h14
`define DSC_ADDR_STATUS  8'h18
`define DSC_ADDR_COUNT   8'h1C

// Control fields
`define DSC_CTRL_MODEL_LSB  0
`define DSC_CTRL_MODEL_MSB  1
`define DSC_CTRL_FORCED     2
`define DSC_CTRL_CNT_CLR    3

// Control models
`define DSC_MODEL_DIRECT_NORMAL   2'h0
`define DSC_MODEL_DIRECT_ENHANCED 2'h1
`define DSC_MODEL_SBO_ENHANCED    2'h2

// Command fields
`define DSC_CMD_CLOSE    0
`define DSC_CMD_REMOTE   1
`define DSC_CMD_OPERATE  2
`define DSC_CMD_SKIP_CHK 3

// Status fields
`define DSC_ST_OPENED    2
`define DSC_ST_CLOSED    3
`define DSC_ST_INTERM    4
`define DSC_ST_OPEN_P    5
`define DSC_ST_CLOSE_P   6
`define DSC_ST_OPER_P    7
`define DSC_ST_SELECTED  8
`define DSC_ST_BUSY      9
`define DSC_ST_ERR_POS   10
`define DSC_ST_REFUSED   11
`define DSC_ST_SBO_EXP   12

// Reset values
`define DSC_CTRL_RST     4'h4
`define DSC_MAXOP_RST    16'h2710
`define DSC_PULSE_RST    16'h03E8
`define DSC_INTER_RST    16'h2710
`define DSC_SBO_RST      16'h1388

// Timing
`define DSC_CLK_NS       10
`define DSC_MS_NS        1000000
`define DSC_MIN_PULSE_MS 16'h03E8
`define DSC_OPER_MS      16'h0096

`endif

// ### rtl/dsc_switch_ctrl.v
// Disconnector control: command checking, timed open/close pulses,
// position decoding and operation counting behind an APB slave.
// Assumes position, permission and interlock inputs are asynchronous pins.
`timescale 1ns/1ps
`include "dsc_regs.vh"

// Overview of operation
// - Check commands, drive switch, report positions
// - Local commands need local permission
// - Remote commands need remote permission
// - Open needs open interlock enable
// - Close needs close interlock enable
// - Block input refuses every operation
// - Three control models, default direct normal
// - Forced check ignores skip-check requests
// - Enhanced models flag late position change
// - Command pulse lasts configured duration
// - Early end on success, minimum 1000 ms
// - Report intermediate after configured wait
// - Selection cancelled after SBO timeout
// - Two-bit position state from position inputs
// - 150 ms operation pulse per operation
// - Resettable counter counts operation pulses
// - Permission and direction interlock both needed
module dsc_switch_ctrl #(
  parameter MS_CYCLES = `DSC_MS_NS / `DSC_CLK_NS
) (
  input  wire        i_sys_clk,
  input  wire        i_reset_n,
  input  wire        i_clk_en,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg         o_pready,
  output reg  [31:0] o_prdata,
  output reg         o_pslverr,
  input  wire        i_local_permit,
  input  wire        i_remote_permit,
  input  wire        i_open_interlock_enable,
  input  wire        i_close_interlock_enable,
  input  wire        i_operation_block,
  input  wire        i_open_position_input,
  input  wire        i_closed_position_input,
  output reg         o_open_command_pulse,
  output reg         o_close_command_pulse,
  output reg         o_operation_pulse,
  output reg  [1:0]  o_position_state,
  output reg         o_opened,
  output reg         o_closed,
  output reg         o_intermediate
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_SEL   = 3'b010;
  localparam ST_PULSE = 3'b100;

  reg  [6:0]  sync1_q;
  reg  [6:0]  sync2_q;
  reg  [16:0] tick_cnt_q;
  reg         tick_q;
  reg  [1:0]  model_q;
  reg         forced_q;
  reg  [15:0] maxop_q;
  reg  [15:0] pulse_q;
  reg  [15:0] inter_q;
  reg  [15:0] sbo_q;
  reg  [2:0]  state_q;
  reg  [15:0] cmd_ms_q;
  reg         sel_dir_q;
  reg         sel_src_q;
  reg         tgt_q;
  reg         op_run_q;
  reg  [15:0] op_ms_q;
  reg  [15:0] inter_ms_q;
  reg  [15:0] oper_ms_q;
  reg  [1:0]  pos_prev_q;
  reg  [31:0] count_q;
  reg         err_pos_q;
  reg         refused_q;
  reg         sbo_exp_q;

  wire        ce       = i_clk_en;
  wire        apb_acc  = i_psel & i_penable & ~o_pready;
  wire        apb_wr   = apb_acc & i_pwrite;
  wire        cmd_wr   = apb_wr & (i_paddr == `DSC_ADDR_CMD);
  wire        st_wr    = apb_wr & (i_paddr == `DSC_ADDR_STATUS);
  wire        ctrl_wr  = apb_wr & (i_paddr == `DSC_ADDR_CTRL);
  wire        c_dir    = i_pwdata[`DSC_CMD_CLOSE];
  wire        c_src    = i_pwdata[`DSC_CMD_REMOTE];
  wire        c_oper   = i_pwdata[`DSC_CMD_OPERATE];
  wire        c_skip   = i_pwdata[`DSC_CMD_SKIP_CHK];
  wire [1:0]  pos_now  = {sync2_q[6], sync2_q[5]};
  wire        tgt_ok   = tgt_q ? (pos_now == 2'h2) : (pos_now == 2'h1);
  wire        cmd_ok   = permit(c_dir, c_src, c_skip, forced_q, sync2_q[4:0]);
  wire        op_event = (pos_now != pos_prev_q) & (pos_now == 2'h1 | pos_now == 2'h2);
  wire [15:0] ms_next  = cmd_ms_q + {15'h0000, tick_q};

  // Source permission, block and direction interlock
  function permit;
    input       dir;
    input       src;
    input       skip;
    input       forced;
    input [4:0] pins;
    reg         src_ok;
    reg         ilk_ok;
    begin
      src_ok = src ? pins[1] : pins[0];
      ilk_ok = dir ? pins[3] : pins[2];
      if (skip & ~forced) begin
        ilk_ok = 1'b1;
      end
      permit = src_ok & ilk_ok & ~pins[4];
    end
  endfunction

  // Pin synchronisers
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else if (ce) begin
      sync1_q <= {i_closed_position_input, i_open_position_input, i_operation_block,
                  i_close_interlock_enable, i_open_interlock_enable,
                  i_remote_permit, i_local_permit};
      sync2_q <= sync1_q;
    end
  end

  // Millisecond tick
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_q <= 17'h00000;
      tick_q     <= 1'b0;
    end else if (ce) begin
      tick_q <= (tick_cnt_q == MS_CYCLES[16:0] - 17'h00001);
      if (tick_cnt_q == MS_CYCLES[16:0] - 17'h00001) begin
        tick_cnt_q <= 17'h00000;
      end else begin
        tick_cnt_q <= tick_cnt_q + 17'h00001;
      end
    end
  end

  // APB slave
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
      model_q   <= `DSC_MODEL_DIRECT_NORMAL;
      forced_q  <= 1'b1;
      maxop_q   <= `DSC_MAXOP_RST;
      pulse_q   <= `DSC_PULSE_RST;
      inter_q   <= `DSC_INTER_RST;
      sbo_q     <= `DSC_SBO_RST;
    end else if (ce) begin
      o_pready  <= apb_acc;
      o_pslverr <= apb_acc & (i_paddr > `DSC_ADDR_COUNT | i_paddr[1:0] != 2'h0);
      o_prdata  <= 32'h00000000;
      if (apb_acc & ~i_pwrite) begin
        case (i_paddr)
          `DSC_ADDR_CTRL:   o_prdata <= {29'h00000000, forced_q, model_q};
          `DSC_ADDR_MAXOP:  o_prdata <= {16'h0000, maxop_q};
          `DSC_ADDR_PULSE:  o_prdata <= {16'h0000, pulse_q};
          `DSC_ADDR_INTER:  o_prdata <= {16'h0000, inter_q};
          `DSC_ADDR_SBO:    o_prdata <= {16'h0000, sbo_q};
          `DSC_ADDR_STATUS: o_prdata <= {19'h00000, sbo_exp_q, refused_q, err_pos_q,
                                         ~state_q[0], state_q[1], o_operation_pulse,
                                         o_close_command_pulse, o_open_command_pulse,
                                         o_intermediate, o_closed, o_opened,
                                         o_position_state};
          `DSC_ADDR_COUNT:  o_prdata <= count_q;
          default:          o_prdata <= 32'h00000000;
        endcase
      end
      if (ctrl_wr) begin
        model_q  <= i_pwdata[`DSC_CTRL_MODEL_MSB:`DSC_CTRL_MODEL_LSB];
        forced_q <= i_pwdata[`DSC_CTRL_FORCED];
      end
      if (apb_wr & i_paddr == `DSC_ADDR_MAXOP) begin
        maxop_q <= i_pwdata[15:0];
      end
      if (apb_wr & i_paddr == `DSC_ADDR_PULSE) begin
        pulse_q <= i_pwdata[15:0];
      end
      if (apb_wr & i_paddr == `DSC_ADDR_INTER) begin
        inter_q <= i_pwdata[15:0];
      end
      if (apb_wr & i_paddr == `DSC_ADDR_SBO) begin
        sbo_q <= i_pwdata[15:0];
      end
    end
  end

  // Command sequencer
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q               <= ST_IDLE;
      cmd_ms_q              <= 16'h0000;
      sel_dir_q             <= 1'b0;
      sel_src_q             <= 1'b0;
      tgt_q                 <= 1'b0;
      o_open_command_pulse  <= 1'b0;
      o_close_command_pulse <= 1'b0;
      refused_q             <= 1'b0;
      sbo_exp_q             <= 1'b0;
    end else if (ce) begin
      if (st_wr & i_pwdata[`DSC_ST_REFUSED]) begin
        refused_q <= 1'b0;
      end
      if (st_wr & i_pwdata[`DSC_ST_SBO_EXP]) begin
        sbo_exp_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (cmd_wr) begin
            if (~cmd_ok | (c_oper == (model_q == `DSC_MODEL_SBO_ENHANCED))) begin
              refused_q <= 1'b1;
            end else if (model_q == `DSC_MODEL_SBO_ENHANCED) begin
              state_q   <= ST_SEL;
              sel_dir_q <= c_dir;
              sel_src_q <= c_src;
              cmd_ms_q  <= 16'h0000;
            end else begin
              state_q               <= ST_PULSE;
              tgt_q                 <= c_dir;
              cmd_ms_q              <= 16'h0000;
              o_close_command_pulse <= c_dir;
              o_open_command_pulse  <= ~c_dir;
            end
          end
        end
        ST_SEL: begin
          cmd_ms_q <= ms_next;
          if (cmd_wr & c_oper & cmd_ok & c_dir == sel_dir_q & c_src == sel_src_q) begin
            state_q               <= ST_PULSE;
            tgt_q                 <= c_dir;
            cmd_ms_q              <= 16'h0000;
            o_close_command_pulse <= c_dir;
            o_open_command_pulse  <= ~c_dir;
          end else if (cmd_wr) begin
            refused_q <= 1'b1;
            state_q   <= ST_IDLE;
          end else if (ms_next >= sbo_q) begin
            sbo_exp_q <= 1'b1;
            state_q   <= ST_IDLE;
          end
        end
        ST_PULSE: begin
          cmd_ms_q <= ms_next;
          if (cmd_wr) begin
            refused_q <= 1'b1;
          end
          if (ms_next >= pulse_q | (tgt_ok & ms_next >= `DSC_MIN_PULSE_MS)) begin
            state_q               <= ST_IDLE;
            o_open_command_pulse  <= 1'b0;
            o_close_command_pulse <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Operating time supervision for enhanced models
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      op_run_q  <= 1'b0;
      op_ms_q   <= 16'h0000;
      err_pos_q <= 1'b0;
    end else if (ce) begin
      if (st_wr & i_pwdata[`DSC_ST_ERR_POS]) begin
        err_pos_q <= 1'b0;
      end
      if (state_q == ST_PULSE & cmd_ms_q == 16'h0000 & ~op_run_q
          & model_q != `DSC_MODEL_DIRECT_NORMAL) begin
        op_run_q <= 1'b1;
        op_ms_q  <= 16'h0000;
      end else if (op_run_q) begin
        op_ms_q <= op_ms_q + {15'h0000, tick_q};
        if (tgt_ok) begin
          op_run_q <= 1'b0;
        end else if (op_ms_q + {15'h0000, tick_q} >= maxop_q) begin
          op_run_q  <= 1'b0;
          err_pos_q <= 1'b1;
        end
      end
    end
  end

  // Position decode, intermediate filter, operation pulse and counter
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_position_state  <= 2'h0;
      o_opened          <= 1'b0;
      o_closed          <= 1'b0;
      o_intermediate    <= 1'b0;
      inter_ms_q        <= 16'h0000;
      pos_prev_q        <= 2'h0;
      oper_ms_q         <= 16'h0000;
      o_operation_pulse <= 1'b0;
      count_q           <= 32'h00000000;
    end else if (ce) begin
      o_position_state <= pos_now;
      o_opened         <= (pos_now == 2'h1);
      o_closed         <= (pos_now == 2'h2);
      pos_prev_q       <= pos_now;
      if (pos_now != 2'h0) begin
        inter_ms_q     <= 16'h0000;
        o_intermediate <= 1'b0;
      end else if (inter_ms_q + {15'h0000, tick_q} >= inter_q) begin
        o_intermediate <= 1'b1;
      end else begin
        inter_ms_q <= inter_ms_q + {15'h0000, tick_q};
      end
      if (op_event) begin
        o_operation_pulse <= 1'b1;
        oper_ms_q         <= 16'h0000;
      end else if (o_operation_pulse) begin
        oper_ms_q <= oper_ms_q + {15'h0000, tick_q};
        if (oper_ms_q + {15'h0000, tick_q} >= `DSC_OPER_MS) begin
          o_operation_pulse <= 1'b0;
        end
      end
      if (op_event & ~o_operation_pulse) begin
        count_q <= (ctrl_wr & i_pwdata[`DSC_CTRL_CNT_CLR]) ? 32'h00000001
                                                             : count_q + 32'h00000001;
      end else if (ctrl_wr & i_pwdata[`DSC_CTRL_CNT_CLR]) begin
        count_q <= 32'h00000000;
      end
    end
  end

endmodule // dsc_switch_ctrl

// ### sim/dsc_switch_model.sv
// Behavioural disconnector that moves once a command pulse has lasted DELAY cycles.
// Assumes command pulses from dsc_switch_ctrl; hold keeps it in mid travel.
`timescale 1ns/1ps
module dsc_switch_model #(
  parameter DELAY = 40
) (
  input  wire i_clk,
  input  wire i_open_cmd,
  input  wire i_close_cmd,
  input  wire i_hold,
  output wire o_open_pos,
  output wire o_closed_pos
);
  reg     closed_q = 1'b0;
  integer n_q      = 0;
  always @(posedge i_clk) begin
    n_q <= (i_open_cmd | i_close_cmd) ? n_q + 1 : 0;
    if (n_q == DELAY && !i_hold)
      closed_q <= i_close_cmd;
  end
  assign o_open_pos   = !i_hold && !closed_q;
  assign o_closed_pos = !i_hold && closed_q;
endmodule // dsc_switch_model

// ### sim/dsc_switch_ctrl_props.sv
// Port checker for the disconnector control block.
// Assumes it is bound into dsc_switch_ctrl with the same MS_CYCLES.
`timescale 1ns/1ps
module dsc_props #(
  parameter MS_CYCLES = 100000
) (
  input wire       i_sys_clk,
  input wire       i_reset_n,
  input wire       i_psel,
  input wire       i_penable,
  input wire       o_pready,
  input wire       i_local_permit,
  input wire       i_remote_permit,
  input wire       i_operation_block,
  input wire       i_open_position_input,
  input wire       i_closed_position_input,
  input wire       o_open_command_pulse,
  input wire       o_close_command_pulse,
  input wire       o_operation_pulse,
  input wire [1:0] o_position_state,
  input wire       o_intermediate
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  reg  [3:0]  age_q;
  reg  [31:0] plen_q;
  reg  [31:0] olen_q;
  wire        cmd = o_open_command_pulse | o_close_command_pulse;
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      age_q  <= 4'h0;
      plen_q <= 32'h0;
      olen_q <= 32'h0;
    end else begin
      age_q  <= (age_q == 4'hF) ? age_q : age_q + 4'h1;
      plen_q <= cmd ? plen_q + 32'h1 : 32'h0;
      olen_q <= o_operation_pulse ? olen_q + 32'h1 : 32'h0;
    end
  end
  property p_pos;
    age_q > 4'h3 |-> o_position_state ==
      {$past(i_closed_position_input, 3), $past(i_open_position_input, 3)};
  endproperty
  a_pos: assert property (p_pos) else $error("position state wrong");
  property p_permit;
    $rose(cmd) |-> $past(i_local_permit, 3) || $past(i_remote_permit, 3);
  endproperty
  a_permit: assert property (p_permit) else $error("pulse without permit");
  property p_block;
    $rose(cmd) |-> !$past(i_operation_block, 3);
  endproperty
  a_block: assert property (p_block) else $error("pulse while blocked");
  property p_rdy;
    i_psel && i_penable && !o_pready |=> o_pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("bus answer late");
  property p_plen;
    $fell(cmd) |-> plen_q >= 99 * MS_CYCLES;
  endproperty
  a_plen: assert property (p_plen) else $error("command pulse short");
  property p_olen;
    $fell(o_operation_pulse) |-> olen_q >= 149 * MS_CYCLES && olen_q <= 150 * MS_CYCLES;
  endproperty
  a_olen: assert property (p_olen) else $error("operation pulse length");
  property p_orise;
    $rose(o_operation_pulse) |-> (o_position_state == 2'h1 || o_position_state == 2'h2) &&
      o_position_state != $past(o_position_state);
  endproperty
  a_orise: assert property (p_orise) else $error("operation pulse cause");
  property p_mid;
    $rose(o_intermediate) |-> o_position_state == 2'h0 && $past(o_position_state) == 2'h0;
  endproperty
  a_mid: assert property (p_mid) else $error("intermediate wrong");
  c_close: cover property ($rose(o_close_command_pulse));
  c_open: cover property ($rose(o_open_command_pulse));
  c_mid: cover property ($rose(o_intermediate));
endmodule // dsc_props
bind dsc_switch_ctrl dsc_props #(.MS_CYCLES(MS_CYCLES)) u_props (.i_sys_clk, .i_reset_n,
  .i_psel, .i_penable, .o_pready, .i_local_permit, .i_remote_permit, .i_operation_block,
  .i_open_position_input, .i_closed_position_input, .o_open_command_pulse,
  .o_close_command_pulse, .o_operation_pulse, .o_position_state, .o_intermediate);

// ### sim/tb.sv
// Self-checking bench for the disconnector control block.
// Assumes dsc_switch_ctrl, dsc_switch_model and the bound checker.
`timescale 1ns/1ps
`include "dsc_regs.vh"
module tb;
  localparam        MS  = 2;
  localparam [53:0] TAB = {9'h0E4, 9'h166, 9'h1A4, 9'h1C5, 9'h1F4, 9'h1AC};
  reg         clk = 0;
  reg         rst_n = 0;
  reg         psel = 0;
  reg         pen = 0;
  reg         pwr = 0;
  reg         hold = 0;
  reg         slv;
  reg  [7:0]  pa = 8'h00;
  reg  [31:0] pwd = 32'h0;
  reg  [31:0] rd;
  reg  [4:0]  pin = 5'h1E;
  reg  [3:0]  cmd;
  wire        rdy, err, opc, clc, op, opd, cld, mid, opos, cpos;
  wire [31:0] prd;
  wire [1:0]  pst;
  integer     mismatches = 0;
  integer     n_tests = 0;
  integer     k;
  always #5 clk = ~clk;
  dsc_switch_ctrl #(.MS_CYCLES(MS)) DUT (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(1'b1),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
    .o_pready(rdy), .o_prdata(prd), .o_pslverr(err), .i_local_permit(pin[4]),
    .i_remote_permit(pin[3]), .i_open_interlock_enable(pin[2]),
    .i_close_interlock_enable(pin[1]), .i_operation_block(pin[0]),
    .i_open_position_input(opos), .i_closed_position_input(cpos),
    .o_open_command_pulse(opc), .o_close_command_pulse(clc), .o_operation_pulse(op),
    .o_position_state(pst), .o_opened(opd), .o_closed(cld), .o_intermediate(mid));
  dsc_switch_model u_sw (.i_clk(clk), .i_open_cmd(opc), .i_close_cmd(clc), .i_hold(hold),
    .o_open_pos(opos), .o_closed_pos(cpos));
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      rd = prd;
      slv = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task pulse_len;
    begin
      k = 0;
      while (opc === 1'b1 || clc === 1'b1) begin
        @(posedge clk);
        k = k + 1;
      end
    end
  endtask
  task t_defaults;
    begin
      xfer(0, `DSC_ADDR_CTRL, 0);
      chk(rd, 32'h4);
      xfer(0, `DSC_ADDR_MAXOP, 0);
      chk(rd, 32'h2710);
      xfer(0, `DSC_ADDR_PULSE, 0);
      chk(rd, 32'h3E8);
      xfer(0, `DSC_ADDR_INTER, 0);
      chk(rd, 32'h2710);
      xfer(0, `DSC_ADDR_SBO, 0);
      chk(rd, 32'h1388);
      xfer(0, 8'h20, 0);
      chk(slv, 1);
      $display("test defaults done");
    end
  endtask
  task t_close;
    begin
      while (op === 1'b1) @(posedge clk);
      xfer(1, `DSC_ADDR_CTRL, 32'hC);
      xfer(1, `DSC_ADDR_PULSE, 32'h7D0);
      xfer(1, `DSC_ADDR_CMD, 32'h5);
      chk(clc, 1);
      pulse_len;
      chk(k >= 1990 && k <= 2000, 1);
      chk(pst, 2);
      chk(cld, 1);
      xfer(0, `DSC_ADDR_COUNT, 0);
      chk(rd, 1);
      $display("test close done");
    end
  endtask
  task t_refuse;
    begin
      for (k = 0; k < 6; k = k + 1) begin
        {pin, cmd} <= TAB[k*9 +: 9];
        cyc(4);
        xfer(1, `DSC_ADDR_CMD, {28'h0, cmd});
        cyc(2);
        chk({opc, clc}, 0);
        xfer(0, `DSC_ADDR_STATUS, 0);
        chk(rd[11], 1);
        xfer(1, `DSC_ADDR_STATUS, 32'h800);
      end
      pin <= 5'h1E;
      cyc(4);
      $display("test refuse done");
    end
  endtask
  task t_sbo;
    begin
      xfer(1, `DSC_ADDR_CTRL, 32'h6);
      xfer(1, `DSC_ADDR_SBO, 32'h3E8);
      xfer(1, `DSC_ADDR_CMD, 32'h0);
      xfer(0, `DSC_ADDR_STATUS, 0);
      chk(rd[8], 1);
      cyc(1000 * MS + 20);
      xfer(0, `DSC_ADDR_STATUS, 0);
      chk(rd[12:8], 5'h10);
      xfer(1, `DSC_ADDR_CMD, 32'h4);
      chk(opc, 0);
      xfer(1, `DSC_ADDR_STATUS, 32'h1800);
      xfer(1, `DSC_ADDR_CMD, 32'h0);
      xfer(1, `DSC_ADDR_CMD, 32'h4);
      chk(opc, 1);
      cyc(60);
      chk(op, 1);
      pulse_len;
      chk(pst, 1);
      chk(opd, 1);
      xfer(0, `DSC_ADDR_COUNT, 0);
      chk(rd, 2);
      $display("test select done");
    end
  endtask
  task t_enh;
    begin
      xfer(1, `DSC_ADDR_CTRL, 32'h5);
      xfer(1, `DSC_ADDR_PULSE, 32'h64);
      xfer(1, `DSC_ADDR_MAXOP, 32'hA);
      xfer(1, `DSC_ADDR_INTER, 32'h14);
      hold <= 1'b1;
      cyc(5);
      xfer(1, `DSC_ADDR_CMD, 32'h5);
      chk(clc, 1);
      pulse_len;
      chk(k >= 190 && k <= 200, 1);
      xfer(0, `DSC_ADDR_STATUS, 0);
      chk(rd[10], 1);
      chk(mid, 1);
      chk(pst, 0);
      xfer(1, `DSC_ADDR_CTRL, 32'hD);
      xfer(0, `DSC_ADDR_COUNT, 0);
      chk(rd, 0);
      $display("test enhanced done");
    end
  endtask
  task give_verdict;
    begin
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #500000;
    mismatches = mismatches + 1;
    give_verdict;
  end
  initial begin
    cyc(4);
    rst_n <= 1'b1;
    cyc(1);
    t_defaults;
    t_close;
    t_refuse;
    t_sbo;
    t_enh;
    give_verdict;
  end
endmodule // tb
